//--- ndch_defines.svh
// Purpose: constants for the node command handler
// Assumes: 100 MHz system clock, 32-bit word framing on the link
// Notes:   offsets are byte addresses on the register bus
`ifndef NDCH_DEFINES_SVH
`define NDCH_DEFINES_SVH

// ==========================================================
// frame layout
`define NDCH_FRAME_BITS    80
`define NDCH_LINK_BITS     96
`define NDCH_LINK_BITS_W   7'd96
`define NDCH_ID_RESP_BIT   15
`define NDCH_ADDR_CUC_BIT  10
`define NDCH_ADDR_COMBINED_DETECT_COINCIDENCE_CONTROLLER_BIT 11
`define NDCH_ADDR_BC_BIT   15
`define NDCH_HOST_ORIGIN   16'h4000

// ==========================================================
// function codes and reply codes
`define NDCH_FN_POLL       15'h0000
`define NDCH_FN_PING       15'h0001
`define NDCH_FN_CFG_KIDS   15'h0002
`define NDCH_FN_WR_MODE    15'h0003
`define NDCH_FN_RD_MODE    15'h0004
`define NDCH_FN_WR_SET     15'h0005
`define NDCH_FN_RD_SET     15'h0006
`define NDCH_FN_WR_ACT     15'h0007
`define NDCH_FN_RD_ACT     15'h0008
`define NDCH_FN_WR_MASK    15'h0009
`define NDCH_FN_RD_MASK    15'h000A
`define NDCH_FN_WR_SRAM    15'h000B
`define NDCH_ERR_FW_UNK    16'h7F04
`define NDCH_BUSY_WORD     16'h0000

// ==========================================================
// register bus map
`define NDCH_OFF_NODE      8'h00
`define NDCH_OFF_MODE      8'h04
`define NDCH_OFF_SET       8'h08
`define NDCH_OFF_ACT       8'h0C
`define NDCH_OFF_MASK      8'h10
`define NDCH_OFF_STATUS    8'h14
`define NDCH_OFF_SRAM_PTR  8'h18
`define NDCH_OFF_PEEK_ADR  8'h1C
`define NDCH_OFF_PEEK_DAT  8'h20

// ==========================================================
// reset values
`define NDCH_RST_NODE      16'h0000
`define NDCH_RST_WORD      32'h0000_0000

// ==========================================================
// memory size
`define NDCH_MEM_AW        8
`define NDCH_MEM_DW        32

`endif

//--- ndch_pkg.sv
// Purpose: shared types for the node command handler
// Assumes: ndch_defines.svh supplies the numbers
// Notes:   none
`include "ndch_defines.svh"

package ndch_pkg;
   typedef logic [`NDCH_MEM_AW-1:0] ndch_maddr_t;
   typedef logic [`NDCH_MEM_DW-1:0] ndch_word_t;
   typedef logic [`NDCH_FRAME_BITS-1:0] ndch_frame_t;
   // gray codes along idle -> exec -> wait
   typedef enum logic [1:0] {
      NDCH_IDLE = 2'b00,
      NDCH_EXEC = 2'b01,
      NDCH_WAIT = 2'b11
   } ndch_state_t;
endpackage

//--- ndch_mem_if.sv
// Purpose: write and peek port of the payload memory
// Assumes: one clock domain
// Notes:   read data arrive one cycle after the address
`timescale 1ns/10ps
`default_nettype none
`include "ndch_defines.svh"

interface ndch_mem_if;
   import ndch_pkg::*;
   logic        wr_en;
   ndch_maddr_t wr_addr;
   ndch_word_t  wr_data;
   ndch_maddr_t rd_addr;
   ndch_word_t  rd_data;
   modport owner  (output wr_en, output wr_addr, output wr_data, output rd_addr,
                   input rd_data);
   modport memory (input wr_en, input wr_addr, input wr_data, input rd_addr,
                   output rd_data);
endinterface
`default_nettype wire

//--- ndch_sram.sv
// Purpose: payload memory written by the SRAM write command
// Assumes: single clock, synchronous write
// Notes:   read data come out of a register
`timescale 1ns/10ps
`default_nettype none
`include "ndch_defines.svh"

module ndch_sram
   import ndch_pkg::*;
(
   input  wire logic   clk_i, // system clock
   ndch_mem_if.memory  mem    // write and peek port
);
   ndch_word_t store [0:(1<<`NDCH_MEM_AW)-1];

   always_ff @(posedge clk_i) begin
      if (mem.wr_en) begin
         store[mem.wr_addr] <= mem.wr_data;
      end
   end

   always_ff @(posedge clk_i) begin
      mem.rd_data <= store[mem.rd_addr];
   end
endmodule // ndch_sram
`default_nettype wire

//--- ndch_node_cmd.sv
// Purpose: command handler of one node on the 32-bit serial command link
// Assumes: link clock is mode 0, far slower than clk_i; frames are 80 bits in 96-bit transfers
// Notes:   a frame whose function code is zero runs nothing; it reads the response back and, if broadcast, is forwarded to the children
//
// Functional notes
// R1: parent writes commands over the 32-bit serial link and reads replies back.
// R2: frame is 80 bits, msb first: id, origin, target, payload.
// R3: low fifteen id bits select the operation.
// R4: replies carry id bit 15 set.
// R5: parent sets id bit 15 for a non-blocking command.
// R6: while a non-blocking command runs, other commands get no response.
// R7: host commands normally carry origin 0x4000.
// R8: address bits 2:0 board, 5:3 unit, 8:6 multiplexer board.
// R9: address bits 9..12 and 14 flag controller roles and host.
// R10: broadcast target forwards to all children, reads back the selected one.
// R11: controller flags in target make that controller execute and reply.
// R12: payload meaning depends on function code.
// R13: code 1 pings back; code 2 configures children from serial memory.
// R14: code 3 writes acquisition mode, code 4 reads it.
// R15: code 5 writes mode settings, code 6 reads them.
// R16: code 7 writes action register, code 8 reads it.
// R17: code 9 loads trigger mask, code 10 reads it.
// R18: code 11 writes payload to memory with auto-increment.
// R19: nothing to report yet returns all zero, meaning busy.
// R20: parent treats 0xFFFF as dead child.
// R21: unknown function code replies with 0x7F04.
// R22: 80-bit frame sent as three 32-bit words, trailing bits zero.
// R23: reply copies origin, target and function code.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ndch_defines.svh"

module ndch_node_cmd
   import ndch_pkg::*;
(
   input  wire logic          clk_i,          // system clock
   input  wire logic          rst_i,          // synchronous reset
   input  wire logic [7:0]    wb_adr_i,       // byte address
   input  wire logic [31:0]   wb_dat_i,       // write data
   output logic [31:0]        wb_dat_o,       // read data
   input  wire logic          wb_we_i,        // write strobe
   input  wire logic [3:0]    wb_sel_i,       // byte enables
   input  wire logic          wb_cyc_i,       // cycle
   input  wire logic          wb_stb_i,       // strobe
   output logic               wb_ack_o,       // acknowledge
   input  wire logic          link_sclk_i,    // link clock from parent
   input  wire logic          link_cs_n_i,    // link select, active low
   input  wire logic          link_mosi_i,    // serial data in
   output logic               link_miso_o,    // serial data out
   output logic               kids_cfg_o,     // children configuration request
   input  wire logic          kids_cfg_done_i,// children configured
   output logic               fwd_valid_o,    // broadcast frame pulse
   output ndch_pkg::ndch_frame_t fwd_frame_o, // frame for the children
   output logic [8:0]         fwd_select_o,   // child to read back
   output logic [31:0]        acq_mode_o,     // acquisition mode
   output logic [31:0]        acq_settings_o, // mode settings
   output logic [31:0]        acq_action_o,   // mode action
   output logic [31:0]        trig_mask_o     // trigger mask
);
   import ndch_pkg::*;

   // =======================================================
   // helpers
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic hit(input logic [15:0] tgt, input logic [15:0] own);
      if (tgt[`NDCH_ADDR_CUC_BIT] | tgt[`NDCH_ADDR_COMBINED_DETECT_COINCIDENCE_CONTROLLER_BIT]) begin // R11
         return (tgt[`NDCH_ADDR_CUC_BIT] & own[`NDCH_ADDR_CUC_BIT]) |
                (tgt[`NDCH_ADDR_COMBINED_DETECT_COINCIDENCE_CONTROLLER_BIT] & own[`NDCH_ADDR_COMBINED_DETECT_COINCIDENCE_CONTROLLER_BIT]);
      end
      return (tgt[12:0] == own[12:0]); // R8 R9
   endfunction

   // =======================================================
   // link pin synchronisers
   logic [2:0] sclk_sy;
   logic [2:0] cs_sy;
   logic [1:0] mosi_sy;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_sy <= 3'h0;
         cs_sy   <= 3'h7;
         mosi_sy <= 2'h0;
      end else begin
         sclk_sy <= {sclk_sy[1:0], link_sclk_i};
         cs_sy   <= {cs_sy[1:0], link_cs_n_i};
         mosi_sy <= {mosi_sy[0], link_mosi_i};
      end
   end
   logic sclk_rise, sclk_fall, cs_start, cs_end, cs_act;
   assign sclk_rise = sclk_sy[1] & ~sclk_sy[2];
   assign sclk_fall = ~sclk_sy[1] & sclk_sy[2];
   assign cs_start  = ~cs_sy[1] & cs_sy[2];
   assign cs_end    = cs_sy[1] & ~cs_sy[2];
   assign cs_act    = ~cs_sy[1];

   // =======================================================
   // serial shifter
   logic [`NDCH_LINK_BITS-1:0] rx_sh;
   logic [`NDCH_LINK_BITS-1:0] tx_sh;
   logic [6:0]  bit_cnt;
   logic        rsp_valid;
   ndch_frame_t rsp_frame;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_sh   <= '0;
         bit_cnt <= 7'h00;
      end else if (cs_start) begin
         bit_cnt <= 7'h00;
      end else if (cs_act && sclk_rise) begin
         rx_sh <= {rx_sh[`NDCH_LINK_BITS-2:0], mosi_sy[1]}; // R1 R2
         if (bit_cnt != 7'h7F) bit_cnt <= bit_cnt + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_sh <= '0;
      end else if (cs_start) begin
         // R19 R22
         tx_sh <= rsp_valid ? {rsp_frame, 16'h0000} : '0;
      end else if (cs_act && sclk_fall) begin
         tx_sh <= {tx_sh[`NDCH_LINK_BITS-2:0], 1'b0};
      end
   end
   assign link_miso_o = tx_sh[`NDCH_LINK_BITS-1];

   // frame taken only when exactly three words arrived
   logic        frame_done;
   ndch_frame_t rx_frame;
   assign frame_done = cs_end && (bit_cnt == `NDCH_LINK_BITS_W); // R22
   assign rx_frame   = rx_sh[`NDCH_LINK_BITS-1:16];

   // =======================================================
   // request decode
   logic [15:0] own_addr;
   logic [15:0] rx_id, rx_org, rx_tgt;
   logic [31:0] rx_pay;
   assign rx_id  = rx_frame[79:64];
   assign rx_org = rx_frame[63:48];
   assign rx_tgt = rx_frame[47:32];
   assign rx_pay = rx_frame[31:0];

   ndch_state_t state, next_state;
   logic        async_busy;
   logic [15:0] q_id, q_org, q_tgt;
   logic [31:0] q_pay;
   logic        accept;
   assign accept = frame_done && (rx_id[14:0] != `NDCH_FN_POLL) && !async_busy &&
                   (state == NDCH_IDLE) &&
                   hit({1'b0, rx_tgt[14:0]}, own_addr);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_id  <= 16'h0000;
         q_org <= 16'h0000;
         q_tgt <= 16'h0000;
         q_pay <= `NDCH_RST_WORD;
      end else if (accept) begin
         q_id  <= rx_id;
         q_org <= rx_org;
         q_tgt <= rx_tgt;
         q_pay <= rx_pay; // R12
      end
   end

   // broadcast forwarding to all children
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fwd_valid_o  <= 1'b0;
         fwd_frame_o  <= '0;
         fwd_select_o <= 9'h000;
      end else begin
         fwd_valid_o <= frame_done && rx_tgt[`NDCH_ADDR_BC_BIT] && !async_busy; // R10
         if (frame_done && rx_tgt[`NDCH_ADDR_BC_BIT]) begin
            fwd_frame_o  <= rx_frame;
            fwd_select_o <= rx_tgt[8:0]; // R10
         end
      end
   end

   // =======================================================
   // execution
   logic [14:0] fn;
   logic        is_cfg;
   assign fn     = q_id[14:0]; // R3
   assign is_cfg = (fn == `NDCH_FN_CFG_KIDS);

   always_comb begin
      next_state = state;
      unique case (state)
         NDCH_IDLE: if (accept) next_state = NDCH_EXEC;
         NDCH_EXEC: next_state = is_cfg ? NDCH_WAIT : NDCH_IDLE;
         NDCH_WAIT: if (kids_cfg_done_i) next_state = NDCH_IDLE;
         default:   next_state = NDCH_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) state <= NDCH_IDLE;
      else       state <= next_state;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)                                 async_busy <= 1'b0;
      else if (accept)                           async_busy <= rx_id[`NDCH_ID_RESP_BIT]; // R5 R6
      else if (next_state == NDCH_IDLE)          async_busy <= 1'b0;
   end

   assign kids_cfg_o = (state == NDCH_WAIT); // R13

   logic exec;
   assign exec = (state == NDCH_EXEC);

   // register bus write strobe
   logic wb_req, wb_wr;
   assign wb_req = wb_cyc_i & wb_stb_i;
   assign wb_wr  = wb_req & wb_we_i & wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) acq_mode_o <= `NDCH_RST_WORD;
      else if (exec && fn == `NDCH_FN_WR_MODE) acq_mode_o <= q_pay; // R14
      else if (wb_wr && wb_adr_i == `NDCH_OFF_MODE)
         acq_mode_o <= merge(acq_mode_o, wb_dat_i, wb_sel_i);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) acq_settings_o <= `NDCH_RST_WORD;
      else if (exec && fn == `NDCH_FN_WR_SET) acq_settings_o <= q_pay; // R15
      else if (wb_wr && wb_adr_i == `NDCH_OFF_SET)
         acq_settings_o <= merge(acq_settings_o, wb_dat_i, wb_sel_i);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) acq_action_o <= `NDCH_RST_WORD;
      else if (exec && fn == `NDCH_FN_WR_ACT) acq_action_o <= q_pay; // R16
      else if (wb_wr && wb_adr_i == `NDCH_OFF_ACT)
         acq_action_o <= merge(acq_action_o, wb_dat_i, wb_sel_i);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) trig_mask_o <= `NDCH_RST_WORD;
      else if (exec && fn == `NDCH_FN_WR_MASK) trig_mask_o <= q_pay; // R17
      else if (wb_wr && wb_adr_i == `NDCH_OFF_MASK)
         trig_mask_o <= merge(trig_mask_o, wb_dat_i, wb_sel_i);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) own_addr <= `NDCH_RST_NODE;
      else if (wb_wr && wb_adr_i == `NDCH_OFF_NODE)
         own_addr <= 16'(merge({16'h0000, own_addr}, wb_dat_i, wb_sel_i));
   end

   // payload memory with auto-increment pointer
   ndch_mem_if mem ();
   ndch_maddr_t sram_ptr, peek_adr;
   assign mem.wr_en   = exec && (fn == `NDCH_FN_WR_SRAM); // R18
   assign mem.wr_addr = sram_ptr;
   assign mem.wr_data = q_pay;
   assign mem.rd_addr = peek_adr;

   always_ff @(posedge clk_i) begin
      if (rst_i) sram_ptr <= '0;
      else if (mem.wr_en) sram_ptr <= sram_ptr + 1'b1; // R18
      else if (wb_wr && wb_adr_i == `NDCH_OFF_SRAM_PTR) sram_ptr <= wb_dat_i[`NDCH_MEM_AW-1:0];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) peek_adr <= '0;
      else if (wb_wr && wb_adr_i == `NDCH_OFF_PEEK_ADR) peek_adr <= wb_dat_i[`NDCH_MEM_AW-1:0];
   end

   ndch_sram u_sram (
      .clk_i (clk_i),
      .mem   (mem.memory)
   );

   // =======================================================
   // response
   logic [31:0] rd_pay;
   logic        known;
   always_comb begin
      known  = 1'b1;
      rd_pay = q_pay;
      unique case (fn)
         `NDCH_FN_PING, `NDCH_FN_CFG_KIDS, `NDCH_FN_WR_MODE, `NDCH_FN_WR_SET,
         `NDCH_FN_WR_ACT, `NDCH_FN_WR_MASK, `NDCH_FN_WR_SRAM: rd_pay = q_pay; // R13
         `NDCH_FN_RD_MODE: rd_pay = acq_mode_o;     // R14
         `NDCH_FN_RD_SET:  rd_pay = acq_settings_o; // R15
         `NDCH_FN_RD_ACT:  rd_pay = acq_action_o;   // R16
         `NDCH_FN_RD_MASK: rd_pay = trig_mask_o;    // R17
         default:          known  = 1'b0;           // R21
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_valid <= 1'b0;
         rsp_frame <= '0;
      end else if ((exec && !is_cfg) || (state == NDCH_WAIT && kids_cfg_done_i)) begin
         rsp_valid <= 1'b1;
         // R4 R23
         rsp_frame <= {known ? {1'b1, fn} : (`NDCH_ERR_FW_UNK | 16'h8000), // R21
                       q_org, q_tgt, rd_pay};
      end else if (accept || cs_start) begin
         rsp_valid <= 1'b0; // R19
      end
   end

   // =======================================================
   // register bus slave
   logic [31:0] rd_mux;
   always_comb begin
      unique case (wb_adr_i)
         `NDCH_OFF_NODE:     rd_mux = {16'h0000, own_addr};
         `NDCH_OFF_MODE:     rd_mux = acq_mode_o;
         `NDCH_OFF_SET:      rd_mux = acq_settings_o;
         `NDCH_OFF_ACT:      rd_mux = acq_action_o;
         `NDCH_OFF_MASK:     rd_mux = trig_mask_o;
         `NDCH_OFF_STATUS:   rd_mux = {27'h0, kids_cfg_o, async_busy, rsp_valid, state};
         `NDCH_OFF_SRAM_PTR: rd_mux = {24'h0, sram_ptr};
         `NDCH_OFF_PEEK_ADR: rd_mux = {24'h0, peek_adr};
         `NDCH_OFF_PEEK_DAT: rd_mux = mem.rd_data;
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= rd_mux;
      end
   end
endmodule // ndch_node_cmd
`default_nettype wire

//--- ndch_node_cmd_props.sv
// Purpose: port-level assertions for the node command handler
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every ndch_node_cmd instance
`timescale 1ns/10ps
`default_nettype none
module ndch_node_cmd_props
   import ndch_pkg::*;
(
   input wire logic                 clk_i,           // system clock
   input wire logic                 rst_i,           // reset
   input wire logic                 wb_cyc_i,        // bus cycle
   input wire logic                 wb_stb_i,        // bus strobe
   input wire logic                 wb_we_i,         // bus write
   input wire logic                 wb_ack_o,        // bus ack
   input wire logic                 link_cs_n_i,     // link select
   input wire logic                 kids_cfg_o,      // cfg request
   input wire logic                 kids_cfg_done_i, // cfg done
   input wire logic                 fwd_valid_o,     // forward pulse
   input wire ndch_pkg::ndch_frame_t fwd_frame_o,    // forwarded frame
   input wire logic [8:0]           fwd_select_o,    // readback child
   input wire logic [31:0]          acq_mode_o,      // mode register
   input wire logic [31:0]          trig_mask_o      // trigger mask
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // bus handshake
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_in_one: assert property (s_req |=> s_ack_pulse)
      else $error("bus request not answered by one ack pulse");
   a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without an earlier request");
   a_ack_with_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
      else $error("ack outside a held request");
   // ==========================================================
   // link side effects
   a_fwd_one_pulse: assert property (fwd_valid_o |=> !fwd_valid_o)
      else $error("forward pulse longer than one cycle");
   a_fwd_select_field: assert property (fwd_valid_o |->
      fwd_select_o == fwd_frame_o[40:32] && fwd_frame_o[47])
      else $error("forwarded select or broadcast flag wrong");
   a_fwd_after_frame: assert property (fwd_valid_o |-> link_cs_n_i)
      else $error("forward pulse inside a frame");
   a_cfg_held: assert property (kids_cfg_o && !kids_cfg_done_i |=> kids_cfg_o)
      else $error("config request dropped before done");
   a_mode_cause: assert property ($changed(acq_mode_o) |->
      $past(wb_ack_o && wb_we_i) || link_cs_n_i)
      else $error("mode changed without a write");
   a_mask_cause: assert property ($changed(trig_mask_o) |->
      $past(wb_ack_o && wb_we_i) || link_cs_n_i)
      else $error("mask changed without a write");
endmodule // ndch_node_cmd_props

bind ndch_node_cmd ndch_node_cmd_props u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .link_cs_n_i(link_cs_n_i),
   .kids_cfg_o(kids_cfg_o), .kids_cfg_done_i(kids_cfg_done_i),
   .fwd_valid_o(fwd_valid_o), .fwd_frame_o(fwd_frame_o),
   .fwd_select_o(fwd_select_o), .acq_mode_o(acq_mode_o), .trig_mask_o(trig_mask_o));
`default_nettype wire

//--- ndch_parent_model.sv
// Purpose: parent node driving the 32-bit word serial command link
// Assumes: mode 0, 160 ns link clock, clock idle low between frames
// Notes:   xfer sends one frame and returns what came back
`timescale 1ns/10ps
`default_nettype none
module ndch_parent_model (
   output logic      sclk_o, // link clock
   output logic      cs_n_o, // select, active low
   output logic      mosi_o, // data to node
   input  wire logic miso_i  // data from node
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic xfer(input logic [79:0] f, output logic [79:0] r);
      logic [95:0] tx;
      logic [95:0] rx;
      tx = {f, 16'h0000};
      cs_n_o = 1'b0;
      #200;
      for (int i = 95; i >= 0; i--) begin
         mosi_o = tx[i];
         #80 sclk_o = 1'b1;
         rx[i] = miso_i;
         #80 sclk_o = 1'b0;
      end
      #80 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      r = rx[95:16];
      #400;
   endtask
endmodule // ndch_parent_model
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the node command handler
// Assumes: node address 0x0002, then 0x0402; host origin on every command
// Notes:   replies are compared with a behavioural model
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ndch_pkg::*;
   localparam logic [15:0] HOST = 16'h4000;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
   logic        clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack, cfg_done;
   logic        sclk, cs_n, mosi, miso, kids_cfg, fwd_valid;
   logic [7:0]  wb_adr;
   logic [31:0] wb_wdat, wb_rdat, q, p, acq_mode, acq_set, acq_act, trig_mask;
   logic [31:0] m_mode, m_set, m_act, m_mask, mem_q[$];
   logic [8:0]  fwd_sel;
   ndch_frame_t fwd_frame, r, e;
   int          failures, checks_done, fwd_seen;
   logic [14:0] codes[10] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 11};

   ndch_node_cmd u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .link_sclk_i(sclk), .link_cs_n_i(cs_n),
      .link_mosi_i(mosi), .link_miso_o(miso), .kids_cfg_o(kids_cfg),
      .kids_cfg_done_i(cfg_done), .fwd_valid_o(fwd_valid), .fwd_frame_o(fwd_frame),
      .fwd_select_o(fwd_sel), .acq_mode_o(acq_mode), .acq_settings_o(acq_set),
      .acq_action_o(acq_act), .trig_mask_o(trig_mask));
   ndch_parent_model u_par (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (fwd_valid === 1'b1) fwd_seen++;

   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      q = wb_rdat;
      {wb_cyc, wb_stb, wb_we} <= 3'b000;
   endtask
   // reply that a node holding the model registers gives
   function automatic ndch_frame_t model(logic [15:0] id, logic [15:0] tg, logic [31:0] d);
      logic [31:0] v = d;
      case (id[14:0])
         3: m_mode = d;
         4: v = m_mode;
         5: m_set = d;
         6: v = m_set;
         7: m_act = d;
         8: v = m_act;
         9: m_mask = d;
         10: v = m_mask;
         11: mem_q.push_back(d);
         1, 2: v = d;
         default: return {16'hFF04, HOST, tg, d};
      endcase
      return {id | 16'h8000, HOST, tg, v};
   endfunction
   task automatic cmd(input logic [15:0] id, input logic [15:0] tg, output ndch_frame_t rr);
      u_par.xfer({id, HOST, tg, p}, rr);
      `CHK(rr, 80'h0)
      u_par.xfer({16'h0000, HOST, tg, 32'h0}, rr);
      `CHK(rr[79:64] !== 16'hFFFF, 1'b1)
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #900us;
      failures++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(17));
      {wb_cyc, wb_stb, wb_we, cfg_done, wb_adr, wb_wdat} = '0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      for (int a = 0; a <= 'h18; a += 4) begin
         wb(a[7:0], 1'b0, 0);
         `CHK(q, 32'h0)
      end
      wb(8'h40, 1'b1, 32'hFFFF_FFFF);
      wb(8'h40, 1'b0, 0);
      `CHK(q, 32'h0)
      wb(8'h00, 1'b1, 32'h0000_0002);
      foreach (codes[i]) begin
         p = $urandom;
         cmd({1'b0, codes[i]}, 16'h0002, r);
         e = model({1'b0, codes[i]}, 16'h0002, p);
         `CHK(r, e)
      end
      `CHK({acq_mode, acq_set, acq_act, trig_mask}, {m_mode, m_set, m_act, m_mask})
      wb(8'h18, 1'b0, 0);
      `CHK(q, 32'h1)
      wb(8'h1C, 1'b1, 0);
      wb(8'h20, 1'b0, 0);
      `CHK(q, mem_q[0])
      p = $urandom;
      cmd(16'h0055, 16'h0002, r);
      `CHK(r, model(16'h0055, 16'h0002, p))
      cmd(16'h0001, 16'h0003, r);
      `CHK(r, 80'h0)
      fwd_seen = 0;
      cmd(16'h0001, 16'h8002, r);
      e = model(16'h0001, 16'h8002, p);
      `CHK(r, e)
      `CHK({fwd_seen, fwd_sel}, {32'd2, 9'h002})
      cmd(16'h0001, 16'h0402, r);
      `CHK(r, 80'h0)
      wb(8'h00, 1'b1, 32'h0000_0402);
      cmd(16'h0001, 16'h0405, r);
      e = model(16'h0001, 16'h0405, p);
      `CHK(r, e)
      cmd(16'h8002, 16'h0405, r);
      `CHK({kids_cfg, r}, {1'b1, 80'h0})
      cmd(16'h0001, 16'h0405, r);
      `CHK(r, 80'h0)
      @(posedge clk_i) cfg_done <= 1'b1;
      @(posedge clk_i) cfg_done <= 1'b0;
      repeat (10) @(posedge clk_i);
      u_par.xfer({16'h0000, HOST, 16'h0405, 32'h0}, r);
      e = model(16'h8002, 16'h0405, p);
      `CHK(r, e)
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire
